// ### common/ppcd_pkg.sv
// Shared constants and carrier types for the port with change detection
package ppcd_pkg;

  // ==========================================================
  // Widths and field positions
  localparam int PORT_WIDTH = 8;
  localparam int CHG_LO = 4;
  localparam int CHG_HI = 7;
  localparam int EDGE_LO = 2;
  localparam int EDGE_HI = 3;
  localparam int TIMER_PIN = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic PULLUP_N_RESET = 1'b1;

  // ==========================================================
  // Timing: one instruction cycle is four system clocks
  localparam int TCY_CLOCKS = 4;

  // Software access strobes to the port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ppcd_acc_s;

  // Pin-side signals
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] outEnN;
    logic [7:0] pullEn;
  } ppcd_pin_s;

endpackage : ppcd_pkg

// ### rtl/ppcd_change_bit.sv
// One change-detection slice: old value capture and mismatch compare
module ppcd_change_bit
  import ppcd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic capture,
  input wire logic isInput,
  input wire logic pinLevel,
  // Result
  output logic mismatch
);

  logic old_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      old_q <= 1'b0;
    end else if (capture) begin
      old_q <= pinLevel;
    end
  end

  assign mismatch = isInput && (pinLevel != old_q);

endmodule : ppcd_change_bit

// ### rtl/ppcd_port.sv
// Eight-bit digital port with shared pull-ups and change detection
module ppcd_port
  import ppcd_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Software access to the port
  input wire ppcd_acc_s portAcc,
  output logic [7:0] portRdata,
  // Direction and latch writes
  input wire logic dirWr,
  input wire logic [7:0] dirWdata,
  output logic [7:0] secondPortDirection,
  output logic [7:0] secondPortOutputLatch,
  // Shared pull-up control, active low
  input wire logic pullupWr,
  input wire logic pullupEnableNWdata,
  output logic pullupEnableN,
  // Change flag
  input wire logic flagClr,
  output logic portChangeFlag,
  output logic wakeReq,
  // Pins
  input wire logic [7:0] secondPortPins,
  output ppcd_pin_s pinDrive,
  // Alternate functions
  output logic [1:0] chargeTimeEdge,
  output logic timerClkGate
);

  // ==========================================================
  // Parameter checks
  // The port logic serves exactly eight pins; refuse anything else
  if (WIDTH != PORT_WIDTH) begin : g_bad_width
    $error("ppcd_port supports only an eight-bit port");
  end

  // The change window is four pins and must fall inside the port
  if (CHG_HI >= WIDTH || CHG_HI - CHG_LO != 3) begin : g_bad_chg
    $error("ppcd_port change window must be four pins of the port");
  end

  if (EDGE_HI >= WIDTH || EDGE_LO > EDGE_HI) begin : g_bad_edge
    $error("ppcd_port edge taps lie outside the port");
  end

  if (TIMER_PIN >= WIDTH) begin : g_bad_timer
    $error("ppcd_port timer tap lies outside the port");
  end

  // The clear hold counter is only two bits wide
  if (TCY_CLOCKS < 1 || TCY_CLOCKS > 4) begin : g_bad_tcy
    $error("ppcd_port instruction cycle must be 1 to 4 clocks");
  end

  // ==========================================================
  // Registers and internal nets
  logic [7:0] dir_q;
  logic [7:0] lat_q;
  logic pullN_q;
  logic flag_q;
  logic [7:0] rdata_q;
  logic [1:0] clrHold_q;
  logic [3:0] mism;
  logic anyMism;
  logic [7:0] pullEn_d;
  logic portTouch;

  // ==========================================================
  // Direction, latch and pull-up control
  // direction register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= DIR_RESET;
    end else if (dirWr) begin
      dir_q <= dirWdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lat_q <= LATCH_RESET;
    end else if (portAcc.wr) begin
      lat_q <= portAcc.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pullN_q <= PULLUP_N_RESET;
    end else if (pullupWr) begin
      pullN_q <= pullupEnableNWdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (portAcc.rd) begin
      rdata_q <= secondPortPins;
    end
  end

  // ==========================================================
  // Pin drive
  // shared pull-up gated by direction
  // An output pin never carries its pull-up, whatever the shared bit says
  assign pullEn_d = {WIDTH{!pullN_q}} & dir_q;

  // Pins follow their registers one clock later; the extra stage keeps
  // every pin-side output straight off a flip-flop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinDrive <= '{
        out: LATCH_RESET,
        outEnN: DIR_RESET,
        pullEn: 8'h00
      };
    end else begin
      pinDrive <= '{
        out: lat_q,
        outEnN: dir_q,
        pullEn: pullEn_d
      };
    end
  end

  // ==========================================================
  // Change detection
  // A write ends a mismatch just as a read does, so any port access
  // refreshes the old values and restarts the clear hold
  assign portTouch = portAcc.rd || portAcc.wr;

  // Old copies start at zero: an upper input pin that sits high out of
  // reset sets the flag again on every clock until the first port access
  generate
    for (genvar i = 0; i <= CHG_HI - CHG_LO; i++) begin : g_chg
      ppcd_change_bit u_bit (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .capture(portTouch),
        .isInput(dir_q[CHG_LO + i]),
        .pinLevel(secondPortPins[CHG_LO + i]),
        .mismatch(mism[i])
      );
    end
  endgenerate

  assign anyMism = |mism;

  // clear blocked for one instruction cycle after access
  // Loaded at the access edge and counted down; a clear is honoured
  // only from the edge one full instruction cycle after the access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clrHold_q <= 2'h0;
    end else if (portTouch) begin
      clrHold_q <= 2'(TCY_CLOCKS - 1);
    end else if (clrHold_q != 2'h0) begin
      clrHold_q <= clrHold_q - 2'h1;
    end
  end

  // set wins over clear
  // A persisting mismatch sets the flag again on every clock, so a clear
  // issued before the mismatch is ended leaves the flag high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= 1'b0;
    end else if (anyMism) begin
      flag_q <= 1'b1;
    end else if (flagClr && clrHold_q == 2'h0) begin
      flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  // Status and read-back come straight from their flip-flops
  assign portChangeFlag = flag_q;
  assign secondPortDirection = dir_q;
  assign secondPortOutputLatch = lat_q;
  assign pullupEnableN = pullN_q;
  assign portRdata = rdata_q;

  // wake request follows flag
  // Whether a wake really happens is left to the sleep control
  assign wakeReq = flag_q;

  // alternate input taps
  // Registered like every other output, so the charge-time and timer
  // users see the pin one clock late
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chargeTimeEdge <= 2'h0;
      timerClkGate <= 1'b0;
    end else begin
      chargeTimeEdge <= secondPortPins[EDGE_HI:EDGE_LO];
      timerClkGate <= secondPortPins[TIMER_PIN];
    end
  end

endmodule : ppcd_port

// ### verif/ppcd_pins_model.sv
// Pin-side model: keys, pull-ups and floating lines
module ppcd_pins_model
  import ppcd_pkg::*;
(
  // Clock and pins
  input wire logic sys_clk,
  input wire ppcd_pin_s pinDrive,
  output logic [7:0] secondPortPins,
  // Keys
  input wire logic [7:0] keyLevel,
  input wire logic [7:0] keyDrive
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unpulled idle lines wander, so no level is trusted
  logic [7:0] float_q = 8'h00;
  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    secondPortPins = ~pinDrive.outEnN & pinDrive.out;
    secondPortPins |= pinDrive.outEnN & keyDrive & keyLevel;
    secondPortPins |= pinDrive.outEnN & ~keyDrive
      & (pinDrive.pullEn | float_q);
  end
endmodule : ppcd_pins_model

// ### verif/ppcd_port_chk.sv
// Concurrent checks on the port's outputs
module ppcd_port_chk
  import ppcd_pkg::*;
(
  // Clock, reset and software side
  input wire logic sys_clk,
  input wire logic nrst,
  input wire ppcd_acc_s portAcc,
  input wire logic [7:0] portRdata,
  input wire logic [7:0] secondPortDirection,
  input wire logic [7:0] secondPortOutputLatch,
  input wire logic pullupEnableN,
  input wire logic flagClr,
  input wire logic portChangeFlag,
  input wire logic wakeReq,
  // Pin side
  input wire logic [7:0] secondPortPins,
  input wire ppcd_pin_s pinDrive,
  input wire logic [1:0] chargeTimeEdge,
  input wire logic timerClkGate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_wake_flag:
    assert property (wakeReq == portChangeFlag) else $error("wake bad");
  a_pull_gate:
    assert property (pinDrive.pullEn == $past(~{8{pullupEnableN}}
      & secondPortDirection)) else $error("pull-up bad");
  a_pin_drive:
    assert property (pinDrive.out == $past(secondPortOutputLatch)
      && pinDrive.outEnN == $past(secondPortDirection)) else $error("drive");
  a_read_pins:
    assert property (portAcc.rd |=> portRdata == $past(secondPortPins))
      else $error("read data bad");
  a_alt_funcs:
    assert property ({timerClkGate, chargeTimeEdge} == $past({
      secondPortPins[5], secondPortPins[3:2]})) else $error("alt bad");
  a_flag_hold:
    assert property (portChangeFlag && !flagClr |=> portChangeFlag)
      else $error("flag dropped");
  a_clr_early:
    assert property (portChangeFlag && (portAcc.rd || portAcc.wr) ##1
      flagClr |=> portChangeFlag) else $error("early clear");
  a_flag_cause:
    assert property ($rose(portChangeFlag) |->
      $past(|secondPortDirection[7:4])) else $error("flag cause");
endmodule : ppcd_port_chk

// ### verif/ppcd_port_tb_top.sv
// Testbench for the port with pull-ups and change detection
module ppcd_port_tb_top
  import ppcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  ppcd_acc_s portAcc = '0;
  logic dirWr = 1'b0, pullupWr = 1'b0, pullupEnableNWdata = 1'b1;
  logic flagClr = 1'b0, pullupEnableN, portChangeFlag, wakeReq, timerClkGate;
  logic [7:0] dirWdata = 8'hff, keyLevel = 8'h00, keyDrive = 8'hff;
  logic [7:0] portRdata, secondPortDirection, secondPortOutputLatch;
  logic [7:0] secondPortPins, d, l, kd, kl, ex;
  logic [1:0] chargeTimeEdge;
  logic pn;
  ppcd_pin_s pinDrive;
  int fail_count = 0, n_tests = 0;
  logic [32:0] rows [4] = '{{8'hff, 8'h00, 1'b0, 8'h00, 8'h00},
    {8'h00, 8'ha5, 1'b0, 8'h00, 8'h00}, {8'hcf, 8'h30, 1'b1, 8'hff, 8'h5a},
    {8'h0f, 8'hc0, 1'b0, 8'h05, 8'h00}};
  always #2 sys_clk = ~sys_clk;
  ppcd_port u_ppcd_port (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .portAcc(portAcc),
    .portRdata(portRdata),
    .dirWr(dirWr),
    .dirWdata(dirWdata),
    .secondPortDirection(secondPortDirection),
    .secondPortOutputLatch(secondPortOutputLatch),
    .pullupWr(pullupWr),
    .pullupEnableNWdata(pullupEnableNWdata),
    .pullupEnableN(pullupEnableN),
    .flagClr(flagClr),
    .portChangeFlag(portChangeFlag),
    .wakeReq(wakeReq),
    .secondPortPins(secondPortPins),
    .pinDrive(pinDrive),
    .chargeTimeEdge(chargeTimeEdge),
    .timerClkGate(timerClkGate)
  );
  ppcd_pins_model u_ppcd_pins_model (
    .sys_clk(sys_clk),
    .pinDrive(pinDrive),
    .secondPortPins(secondPortPins),
    .keyLevel(keyLevel),
    .keyDrive(keyDrive)
  );
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic cfg(input logic [7:0] dv, lv, input logic pv);
    {dirWr, dirWdata, pullupWr, pullupEnableNWdata} = {1'b1, dv, 1'b1, pv};
    portAcc = '{1'b0, 1'b1, lv};
    step(1);
    {dirWr, pullupWr, portAcc} = '0;
    step(2);
  endtask : cfg
  task automatic rd();
    portAcc.rd = 1'b1;
    step(1);
    portAcc.rd = 1'b0;
  endtask : rd
  task automatic clr();
    flagClr = 1'b1;
    step(1);
    flagClr = 1'b0;
  endtask : clr
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
  initial begin
    step(16);
    nrst = 1'b1;
    step(1);
    foreach (rows[i]) begin
      {d, l, pn, kd, kl} = rows[i];
      {keyDrive, keyLevel} = {kd, kl};
      cfg(d, l, pn);
      rd();
      chk(pinDrive.outEnN, d);
      chk(pinDrive.out, l);
      chk(pinDrive.pullEn, pn ? 8'h00 : d);
      ex = ~d & l | d & kd & kl | d & ~kd & {8{~pn}};
      chk(portRdata, ex);
      chk(8'(timerClkGate), 8'(ex[TIMER_PIN]));
      chk(8'(chargeTimeEdge), 8'(ex[EDGE_HI:EDGE_LO]));
      chk(secondPortDirection, d);
      chk(secondPortOutputLatch, l);
      chk(8'(pullupEnableN), 8'(pn));
      $display("row %0d done", i);
      step(1);
    end
    {keyDrive, keyLevel, nrst} = {8'hff, 8'h00, 1'b0};
    step(1);
    chk(secondPortDirection, DIR_RESET);
    chk(secondPortOutputLatch, LATCH_RESET);
    chk(8'(pullupEnableN), 8'h01);
    chk(pinDrive.pullEn, 8'h00);
    nrst = 1'b1;
    $display("reset test done");
    cfg(8'hff, 8'h00, 1'b0);
    rd();
    keyLevel = 8'h0f;
    step(3);
    chk(8'(portChangeFlag), 8'h00);
    cfg(8'h7f, 8'h80, 1'b0);
    chk(8'(portChangeFlag), 8'h00);
    keyLevel = 8'h4f;
    step(2);
    chk(8'(portChangeFlag), 8'h01);
    chk(8'(wakeReq), 8'h01);
    clr();
    chk(8'(portChangeFlag), 8'h01);
    rd();
    clr();
    chk(8'(portChangeFlag), 8'h01);
    step(3);
    clr();
    chk(8'(portChangeFlag), 8'h00);
    chk(8'(chargeTimeEdge), 8'h03);
    chk(8'(timerClkGate), 8'h00);
    $display("change test done");
    conclude();
  end
endmodule : ppcd_port_tb_top
bind ppcd_port ppcd_port_chk u_ppcd_port_chk (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .portAcc(portAcc),
  .portRdata(portRdata),
  .secondPortDirection(secondPortDirection),
  .secondPortOutputLatch(secondPortOutputLatch),
  .pullupEnableN(pullupEnableN),
  .flagClr(flagClr),
  .portChangeFlag(portChangeFlag),
  .wakeReq(wakeReq),
  .secondPortPins(secondPortPins),
  .pinDrive(pinDrive),
  .chargeTimeEdge(chargeTimeEdge),
  .timerClkGate(timerClkGate)
);
